/* File: vws_map.svh */
// constants of the write-only voltage-code serial slave
`ifndef VWS_MAP_SVH
`define VWS_MAP_SVH

// ----------------------------------------------------------------
// address
// ----------------------------------------------------------------
`define VWS_ADDR_UPPER      5'h0d
`define VWS_DIR_WRITE       1'b0

// ----------------------------------------------------------------
// data byte fields and codes
// ----------------------------------------------------------------
`define VWS_PARITY_POS      7
`define VWS_CODE_MAX        7'h4c
`define VWS_CODE_PG_ZERO    7'h78
`define VWS_CODE_PG_FOUR_A  7'h79
`define VWS_CODE_PG_EIGHT   7'h7a
`define VWS_CODE_PG_FOUR_B  7'h7b
`define VWS_CODE_EXT_MODE   7'h7f

// ----------------------------------------------------------------
// reset values and delay settings
// ----------------------------------------------------------------
`define VWS_VID_RST         7'h00
`define VWS_PG_DLY_ZERO     5'h00
`define VWS_PG_DLY_FOUR     5'h04
`define VWS_PG_DLY_EIGHT    5'h08
`define VWS_PG_DLY_RST      5'h04

// ----------------------------------------------------------------
// framing and timing
// ----------------------------------------------------------------
`define VWS_BITS_PER_BYTE   4'h8
`define VWS_BUS_FREE_NS     1300
`define VWS_CORE_PERIOD_NS  50
`define VWS_BUS_FREE_CYC    ((`VWS_BUS_FREE_NS + `VWS_CORE_PERIOD_NS - 1) / `VWS_CORE_PERIOD_NS)

`endif

/* File: vws_pkg.sv */
// types of the write-only voltage-code serial slave
package vws_pkg;

  // receiver states on the serial clock
  typedef enum logic [1:0] {
    VWS_LK_IGNORE = 2'b00,
    VWS_LK_ADDR   = 2'b01,
    VWS_LK_DATA   = 2'b10
  } vws_link_state_t;

  // state clocked by the serial clock
  typedef struct packed {
    vws_link_state_t state;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic            ack_pend;
    logic            start_seen;
    logic [6:0]      code;
    logic            done_tog;
  } vws_link_t;

  // state clocked by the core clock
  typedef struct packed {
    logic       active;
    logic [1:0] strap;
    logic       done_seen;
    logic       write_pulse;
    logic       int_mode;
    logic [6:0] vid_code;
    logic [4:0] pg_delay;
    logic       start_seen;
    logic       stop_seen;
    logic       busy;
    logic [7:0] free_cnt;
  } vws_core_t;

endpackage

/* File: vws_sync.sv */
// multi-bit level synchroniser into the core clock
`timescale 1ns/100ps
module vws_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             i_clk,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("vws_sync needs at least two stages");
  end

  // ----------------------------------------------------------------
  // flop chain, first stage read only by the second
  // ----------------------------------------------------------------
  logic [STAGES-1:0][WIDTH-1:0] chain;

  // shift the chain each core edge
  always_ff @(posedge i_clk) begin
    chain <= {chain[STAGES-2:0], i_async};
  end

  assign o_sync = chain[STAGES-1];

endmodule

/* File: vws_cond_det.sv */
// start and stop condition detector clocked by data line edges
`timescale 1ns/100ps
module vws_cond_det (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_clear,
  output logic      o_start_tog,
  output logic      o_stop_tog
);

  // ----------------------------------------------------------------
  // start: data falls while clock high
  // ----------------------------------------------------------------
  always_ff @(negedge i_sda or posedge i_clear) begin
    if (i_clear) begin
      o_start_tog <= 1'b0;
    end else if (i_scl) begin
      o_start_tog <= ~o_start_tog;
    end
  end

  // ----------------------------------------------------------------
  // stop: data rises while clock high
  // ----------------------------------------------------------------
  always_ff @(posedge i_sda or posedge i_clear) begin
    if (i_clear) begin
      o_stop_tog <= 1'b0;
    end else if (i_scl) begin
      o_stop_tog <= ~o_stop_tog;
    end
  end

endmodule

/* File: vws_top.sv */
// write-only voltage-code serial slave: receiver and code applier
// Notes on behaviour
// - inactive until enabled and soft start done
// - interface wakes when soft-start level input set
// - external regulation until first accepted write of a code 0 to 76
// - accepted write of a code 0 to 76 selects internal regulation
// - slave receiver only, drives only acknowledges
// - transfer is one address byte, one data
// - data stable while clock high, one clock/bit
// - bytes arrive most significant bit first
// - start and stop detected with clock high
// - repeated start restarts address reception
// - eight data clocks plus acknowledge clock
// - own address acknowledged on ninth clock
// - foreign address ignored until next start
// - good-parity data acknowledged and applied
// - bad parity: no acknowledge, nothing changes
// - low address bits come from straps
// - address range 34h to 37h
// - top data bit is even parity
// - codes 0 to 76 set output voltage
// - special codes set delay or external mode
`timescale 1ns/100ps
`include "vws_map.svh"
module vws_top #(
  parameter int BUS_FREE_CYC = `VWS_BUS_FREE_CYC
) (
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_RST,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  input  wire logic       I_ADDR_STRAP_LOW,
  input  wire logic       I_ADDR_STRAP_HIGH,
  input  wire logic       I_ENABLE,
  input  wire logic       I_SS_DONE,
  output logic            O_SDA_OUT,
  output logic            O_SDA_OE,
  output logic            O_IF_ACTIVE,
  output logic            O_INT_MODE,
  output logic            O_DIVIDER_FEEDBACK_PIN_SEL,
  output logic [6:0]      O_VID_CODE,
  output logic [4:0]      O_PG_DELAY,
  output logic            O_WRITE_DONE,
  output logic            O_BUS_BUSY
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (BUS_FREE_CYC < 1 || BUS_FREE_CYC > 255) begin : g_bad_free
    $error("BUS_FREE_CYC must lie in 1..255");
  end

  localparam logic [7:0] FREE_CYC = 8'(BUS_FREE_CYC);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // even parity: top bit equals xor of the code bits
  function automatic logic parity_ok(input logic [7:0] b);
    parity_ok = (b[`VWS_PARITY_POS] == ^b[6:0]);
  endfunction

  // own address with write direction
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [1:0] strap);
    addr_match = (b[7:3] == `VWS_ADDR_UPPER) && (b[2:1] == strap)
                 && (b[0] == `VWS_DIR_WRITE);
  endfunction

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  vws_pkg::vws_core_t core_q;
  vws_pkg::vws_core_t next_core;
  vws_pkg::vws_link_t link_q;
  vws_pkg::vws_link_t next_link;
  logic               ack_drive;
  logic               link_clear;
  logic               start_tog;
  logic               stop_tog;
  logic [6:0]         sync_in;
  logic [6:0]         sync_out;
  logic               en_s;
  logic               ss_s;
  logic [1:0]         strap_s;
  logic               done_s;
  logic               start_s;
  logic               stop_s;
  logic               active_in;
  logic [7:0]         sh_next;

  // ----------------------------------------------------------------
  // link-side reset
  // ----------------------------------------------------------------

  // link logic held clear while the core says inactive
  assign link_clear = ~core_q.active;

  // ----------------------------------------------------------------
  // start and stop detection
  // ----------------------------------------------------------------
  vws_cond_det u_cond (
    .i_scl       (I_SCL),
    .i_sda       (I_SDA),
    .i_clear     (link_clear),
    .o_start_tog (start_tog),
    .o_stop_tog  (stop_tog)
  );

  // ----------------------------------------------------------------
  // synchronisers into the core clock
  // ----------------------------------------------------------------

  // pins and link toggles gathered for one chain
  assign sync_in = {stop_tog, start_tog, link_q.done_tog,
                    I_ADDR_STRAP_HIGH, I_ADDR_STRAP_LOW,
                    I_SS_DONE, I_ENABLE};

  vws_sync #(
    .WIDTH  (7),
    .STAGES (2)
  ) u_sync (
    .i_clk   (I_CORE_CLK),
    .i_async (sync_in),
    .o_sync  (sync_out)
  );

  // unpack the synchronised bits
  assign en_s    = sync_out[0];
  assign ss_s    = sync_out[1];
  assign strap_s = sync_out[3:2];
  assign done_s  = sync_out[4];
  assign start_s = sync_out[5];
  assign stop_s  = sync_out[6];

  // ----------------------------------------------------------------
  // core domain next state
  // ----------------------------------------------------------------
  always_comb begin
    next_core             = core_q;
    next_core.write_pulse = 1'b0;
    active_in             = en_s & ss_s;
    next_core.active      = active_in;

    // capture straps as the interface wakes up
    if (!core_q.active && active_in) begin
      next_core.strap = strap_s;
    end

    // disable or soft-start loss returns to defaults
    if (!active_in) begin
      next_core.int_mode   = 1'b0;
      next_core.vid_code   = `VWS_VID_RST;
      next_core.pg_delay   = `VWS_PG_DLY_RST;
      next_core.done_seen  = 1'b0;
      next_core.start_seen = 1'b0;
      next_core.stop_seen  = 1'b0;
      next_core.busy       = 1'b0;
      next_core.free_cnt   = 8'h00;
    end else begin
      // an accepted data byte arrives as a toggle
      if (done_s != core_q.done_seen) begin
        next_core.done_seen   = done_s;
        next_core.write_pulse = 1'b1;
        // code held stable in the link register
        if (link_q.code <= `VWS_CODE_MAX) begin
          next_core.vid_code = link_q.code;
          next_core.int_mode = 1'b1;
        end else begin
          unique case (link_q.code)
            `VWS_CODE_PG_ZERO: begin
              next_core.pg_delay = `VWS_PG_DLY_ZERO;
            end
            `VWS_CODE_PG_FOUR_A: begin
              next_core.pg_delay = `VWS_PG_DLY_FOUR;
            end
            `VWS_CODE_PG_EIGHT: begin
              next_core.pg_delay = `VWS_PG_DLY_EIGHT;
            end
            `VWS_CODE_PG_FOUR_B: begin
              next_core.pg_delay = `VWS_PG_DLY_FOUR;
            end
            `VWS_CODE_EXT_MODE: begin
              next_core.int_mode = 1'b0;
            end
            default: begin
              next_core.int_mode = core_q.int_mode;
            end
          endcase
        end
      end

      // bus-free countdown after a stop
      if (core_q.free_cnt != 8'h00) begin
        next_core.free_cnt = core_q.free_cnt - 8'h01;
        if (core_q.free_cnt == 8'h01) begin
          next_core.busy = 1'b0;
        end
      end

      // stop starts the idle timer
      if (stop_s != core_q.stop_seen) begin
        next_core.stop_seen = stop_s;
        next_core.free_cnt  = FREE_CYC;
      end

      // start or repeated start marks the bus busy
      if (start_s != core_q.start_seen) begin
        next_core.start_seen = start_s;
        next_core.busy       = 1'b1;
        next_core.free_cnt   = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // core domain register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      core_q <= '{active:     1'b0,
                  strap:      2'b00,
                  done_seen:  1'b0,
                  write_pulse:1'b0,
                  int_mode:   1'b0,
                  vid_code:   `VWS_VID_RST,
                  pg_delay:   `VWS_PG_DLY_RST,
                  start_seen: 1'b0,
                  stop_seen:  1'b0,
                  busy:       1'b0,
                  free_cnt:   8'h00};
    end else begin
      core_q <= next_core;
    end
  end

  // ----------------------------------------------------------------
  // link domain next state, sampled on serial clock rise
  // ----------------------------------------------------------------

  // byte as it stands after this edge's bit
  assign sh_next = {link_q.shreg[6:0], I_SDA};

  always_comb begin
    next_link = link_q;
    // start toggles long before the next clock rise
    if (start_tog != link_q.start_seen) begin
      next_link.start_seen = start_tog;
      next_link.state      = vws_pkg::VWS_LK_ADDR;
      next_link.shreg      = {7'h00, I_SDA};
      next_link.bit_cnt    = 4'h1;
      next_link.ack_pend   = 1'b0;
    end else begin
      unique case (link_q.state)
        vws_pkg::VWS_LK_IGNORE: begin
          next_link.ack_pend = 1'b0;
        end
        vws_pkg::VWS_LK_ADDR,
        vws_pkg::VWS_LK_DATA: begin
          if (link_q.bit_cnt < `VWS_BITS_PER_BYTE) begin
            // one bit per clock pulse
            next_link.shreg   = sh_next;
            next_link.bit_cnt = link_q.bit_cnt + 4'h1;
            if (link_q.bit_cnt == `VWS_BITS_PER_BYTE - 4'h1) begin
              if (link_q.state == vws_pkg::VWS_LK_ADDR) begin
                next_link.ack_pend = addr_match(sh_next,
                                                core_q.strap);
              end else begin
                next_link.ack_pend = parity_ok(sh_next);
              end
            end
          end else begin
            // ninth clock closes the byte
            next_link.ack_pend = 1'b0;
            next_link.bit_cnt  = 4'h0;
            if (!link_q.ack_pend) begin
              next_link.state = vws_pkg::VWS_LK_IGNORE;
            end else if (link_q.state == vws_pkg::VWS_LK_ADDR) begin
              next_link.state = vws_pkg::VWS_LK_DATA;
            end else begin
              next_link.code     = link_q.shreg[6:0];
              next_link.done_tog = ~link_q.done_tog;
              next_link.state    = vws_pkg::VWS_LK_IGNORE;
            end
          end
        end
        default: begin
          next_link.state = vws_pkg::VWS_LK_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link domain register, cleared while inactive
  // ----------------------------------------------------------------
  always_ff @(posedge I_SCL or posedge link_clear) begin
    if (link_clear) begin
      link_q <= '{state:      vws_pkg::VWS_LK_IGNORE,
                  bit_cnt:    4'h0,
                  shreg:      8'h00,
                  ack_pend:   1'b0,
                  start_seen: 1'b0,
                  code:       7'h00,
                  done_tog:   1'b0};
    end else begin
      link_q <= next_link;
    end
  end

  // ----------------------------------------------------------------
  // acknowledge drive, changed on serial clock fall
  // ----------------------------------------------------------------

  // pull low across the ninth clock only
  always_ff @(negedge I_SCL or posedge link_clear) begin
    if (link_clear) begin
      ack_drive <= 1'b0;
    end else begin
      ack_drive <= link_q.ack_pend
                   && (link_q.bit_cnt == `VWS_BITS_PER_BYTE)
                   && (link_q.state != vws_pkg::VWS_LK_IGNORE);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // line only ever pulled low for acknowledges
  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE  = ack_drive & core_q.active;

  // regulation and status
  assign O_IF_ACTIVE                = core_q.active;
  assign O_INT_MODE                 = core_q.int_mode;
  assign O_DIVIDER_FEEDBACK_PIN_SEL = ~core_q.int_mode;
  assign O_VID_CODE                 = core_q.vid_code;
  assign O_PG_DELAY                 = core_q.pg_delay;
  assign O_WRITE_DONE               = core_q.write_pulse;
  assign O_BUS_BUSY                 = core_q.busy;

endmodule

/* File: vws_checker.sv */
// assertion checker for the voltage-code serial slave
`timescale 1ns/100ps
module vws_checker #(
  parameter int BUS_FREE_CYC = 26
) (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RST,
  input wire logic       I_SCL,
  input wire logic       I_SDA,
  input wire logic       I_ADDR_STRAP_LOW,
  input wire logic       I_ADDR_STRAP_HIGH,
  input wire logic       I_ENABLE,
  input wire logic       I_SS_DONE,
  input wire logic       O_SDA_OUT,
  input wire logic       O_SDA_OE,
  input wire logic       O_IF_ACTIVE,
  input wire logic       O_INT_MODE,
  input wire logic       O_DIVIDER_FEEDBACK_PIN_SEL,
  input wire logic [6:0] O_VID_CODE,
  input wire logic [4:0] O_PG_DELAY,
  input wire logic       O_WRITE_DONE,
  input wire logic       O_BUS_BUSY
);
  logic [7:0] idle_cnt;

  // ----------------------------------------------------------------
  // bus idle counter
  // ----------------------------------------------------------------
  // core cycles with both lines high, saturating
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !(I_SCL && I_SDA)) begin
      idle_cnt <= 8'h00;
    end else if (idle_cnt != 8'hff) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sda_out_zero_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !O_SDA_OUT && (!O_SDA_OE || O_BUS_BUSY)) else $error("data line driven outside a frame");
  silent_inactive_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !O_IF_ACTIVE |-> !O_SDA_OE && !O_BUS_BUSY && !O_WRITE_DONE && !O_INT_MODE)
    else $error("activity while inactive");
  fb_select_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      O_DIVIDER_FEEDBACK_PIN_SEL == !O_INT_MODE) else $error("feedback select wrong");
  mode_on_write_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST) $rose(O_INT_MODE) |-> O_WRITE_DONE)
    else $error("internal mode without write");
  vid_on_write_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !$stable(O_VID_CODE) |-> O_WRITE_DONE || O_VID_CODE == 7'h00) else $error("code moved");
  vid_legal_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST) O_VID_CODE <= 7'h4c)
    else $error("illegal code applied");
  pg_values_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !$stable(O_PG_DELAY) |-> O_WRITE_DONE || O_PG_DELAY == 5'h04) else $error("delay moved");
  pg_legal_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      O_PG_DELAY inside {5'h00, 5'h04, 5'h08}) else $error("delay value illegal");
  ack_one_clock_a:
    assert property (@(posedge I_SCL) disable iff (I_RST || !O_IF_ACTIVE)
      O_SDA_OE |=> !O_SDA_OE) else $error("acknowledge too long");
  bus_free_a:
    assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      $fell(O_BUS_BUSY) && O_IF_ACTIVE |-> idle_cnt >= BUS_FREE_CYC)
    else $error("bus freed early");

  // main scenarios reached
  cover property (@(posedge I_CORE_CLK) O_WRITE_DONE && O_INT_MODE);
  cover property (@(posedge I_CORE_CLK) $fell(O_INT_MODE) && O_IF_ACTIVE);
  cover property (@(posedge I_CORE_CLK) O_SDA_OE);
endmodule

bind vws_top vws_checker #(.BUS_FREE_CYC(BUS_FREE_CYC)) chk (
  .I_CORE_CLK, .I_RST, .I_SCL, .I_SDA, .I_ADDR_STRAP_LOW, .I_ADDR_STRAP_HIGH, .I_ENABLE,
  .I_SS_DONE, .O_SDA_OUT, .O_SDA_OE, .O_IF_ACTIVE, .O_INT_MODE, .O_DIVIDER_FEEDBACK_PIN_SEL,
  .O_VID_CODE, .O_PG_DELAY, .O_WRITE_DONE, .O_BUS_BUSY
);

/* File: vws_master_model.sv */
// two-wire bus master model, clock half period 16 ns
`timescale 1ns/100ps
module vws_master_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // idle bus: clock high, data released
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // start or repeated start: data falls with clock high
  task automatic start();
    o_sda_low = 1'b0;
    #8 o_scl = 1'b1;
    #64 o_sda_low = 1'b1;
    #64 o_scl = 1'b0;
  endtask

  // one bit: data set while clock low, sampled mid high
  task automatic send_bit(input logic b, output logic seen);
    #8 o_sda_low = ~b;
    #8 o_scl = 1'b1;
    #8 seen = i_sda;
    #8 o_scl = 1'b0;
  endtask

  // eight bits then a released ninth clock
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) send_bit(v[i], s);
    send_bit(1'b1, s);
    ack = ~s;
  endtask

  // stop then the bus free time
  task automatic stop();
    #8 o_sda_low = 1'b1;
    #8 o_scl = 1'b1;
    #16 o_sda_low = 1'b0;
    #1300;
  endtask

  // address byte, one data byte, stop
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic aa, output logic ad);
    start();
    send_byte(a, aa);
    send_byte(d, ad);
    stop();
  endtask
endmodule

/* File: tb.sv */
// self-checking bench of the voltage-code serial slave
`timescale 1ns/100ps
`include "vws_map.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  typedef struct packed {
    logic [6:0] vid;
    logic [4:0] pg;
    logic       im;
  } vws_exp_t;
  localparam logic [6:0] SP [6] = '{7'h78, 7'h79, 7'h7b, 7'h7a, 7'h4d, 7'h7f};
  logic        clk, rst, scl, sda_low, sl, sh, en, ss;
  wire logic   sda;
  logic        oe, sda_out, act, im, fb, done, busy;
  logic [6:0]  vid, e_vid;
  logic [4:0]  pg, e_pg;
  logic        e_im;
  logic [31:0] rs;
  int          fails, samples_checked;
  vws_exp_t    q[$];
  vws_exp_t    n;

  // open-drain data line with pull-up
  assign sda = ~(sda_low | (oe & ~sda_out));

  vws_top #(.BUS_FREE_CYC(4)) dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .I_ADDR_STRAP_LOW(sl),
    .I_ADDR_STRAP_HIGH(sh), .I_ENABLE(en), .I_SS_DONE(ss), .O_SDA_OUT(sda_out),
    .O_SDA_OE(oe), .O_IF_ACTIVE(act), .O_INT_MODE(im), .O_DIVIDER_FEEDBACK_PIN_SEL(fb),
    .O_VID_CODE(vid), .O_PG_DELAY(pg), .O_WRITE_DONE(done), .O_BUS_BUSY(busy)
  );
  vws_master_model master (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // core clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one transfer; the expected outcome is noted first
  task automatic wr(input logic [7:0] a, input logic [6:0] c, input logic bad, input logic ea);
    logic aa, ad, ed;
    ed = ea & ~bad;
    if (ed) begin
      case (c)
        7'h78: e_pg = 5'h00;
        7'h79, 7'h7b: e_pg = 5'h04;
        7'h7a: e_pg = 5'h08;
        7'h7f: e_im = 1'b0;
        default: begin
          if (c <= 7'h4c) begin
            e_vid = c;
            e_im  = 1'b1;
          end
        end
      endcase
      q.push_back({e_vid, e_pg, e_im});
    end
    master.xfer(a, {^c ^ bad, c}, aa, ad);
    `CHK("address ack", ea, aa)
    `CHK("data ack", ed, ad)
    `CHK("pending notes", 0, q.size())
    `CHK("vid code", e_vid, vid)
    `CHK("delay", e_pg, pg)
    `CHK("int mode", e_im, im)
    `CHK("feedback sel", ~e_im, fb)
    `CHK("bus busy", 1'b0, busy)
  endtask

  // watcher: each done pulse takes the oldest note
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) begin
        `CHK("spurious done", 1'b0, 1'b1)
      end else begin
        n = q.pop_front();
        `CHK("done vid", n.vid, vid)
        `CHK("done delay", n.pg, pg)
        `CHK("done mode", n.im, im)
      end
    end
  end

  // hang guard
  initial begin
    #300000;
    fails++;
    tally_and_finish();
  end

  initial begin
    logic       b;
    logic [1:0] st;
    logic [7:0] own;
    rst   = 1'b1;
    en    = 1'b0;
    ss    = 1'b0;
    sl    = 1'b0;
    sh    = 1'b0;
    rs    = 32'h1f;
    e_vid = 7'h00;
    e_pg  = 5'h04;
    e_im  = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    en  = 1'b1;
    // enabled, soft start pending: silent
    wr({`VWS_ADDR_UPPER, 2'b00, `VWS_DIR_WRITE}, 7'h10, 1'b0, 1'b0);
    rs  = xs(rs);
    st  = rs[1:0];
    own = {`VWS_ADDR_UPPER, st, `VWS_DIR_WRITE};
    @(negedge clk);
    sh = st[1];
    sl = st[0];
    ss = 1'b1;
    for (int i = 0; i < 10 && act !== 1'b1; i++) @(negedge clk);
    `CHK("if active", 1'b1, act)
    if (act !== 1'b1) tally_and_finish();
    $display("test wake done");
    // every strap address, only ours answered
    for (int k = 0; k < 4; k++) begin
      wr({`VWS_ADDR_UPPER, k[1:0], 1'b0}, 7'h20, 1'b0, k[1:0] == st);
    end
    wr({`VWS_ADDR_UPPER, st, 1'b1}, 7'h21, 1'b0, 1'b0);
    wr({5'h0c, st, 1'b0}, 7'h22, 1'b0, 1'b0);
    $display("test address done");
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      wr(own, 7'(rs % 77), 1'b0, 1'b1);
    end
    wr(own, 7'h4c, 1'b0, 1'b1);
    wr(own, 7'h33, 1'b1, 1'b1);
    wr(own, 7'h33, 1'b0, 1'b1);
    $display("test codes done");
    foreach (SP[i]) wr(own, SP[i], 1'b0, 1'b1);
    wr(own, 7'h01, 1'b0, 1'b1);
    $display("test special done");
    // aborted address, then a repeated start
    master.start();
    repeat (4) @(negedge clk);
    `CHK("busy in frame", 1'b1, busy)
    for (int k = 0; k < 3; k++) master.send_bit(1'b1, b);
    wr(own, 7'h02, 1'b0, 1'b1);
    $display("test restart done");
    // disable returns the defaults
    @(negedge clk);
    en = 1'b0;
    repeat (4) @(negedge clk);
    e_vid = 7'h00;
    e_pg  = 5'h04;
    e_im  = 1'b0;
    `CHK("if active", 1'b0, act)
    wr(own, 7'h05, 1'b0, 1'b0);
    $display("test disable done");
    tally_and_finish();
  end
endmodule
